// *** rtl/pths_target.sv ***
`timescale 1ns/1ps
// What this block does
// - answer a 7-bit address whose upper five bits are 01000
// - low two address bits come from the four-state strap pin
// - support send, receive, write and read byte, read word, block read
// - append packet error code to reads, accept it at end of writes
// - packet error code optional per message, no enable needed
// - bad packet error code on a write discards it and sets a flag
// - a start, one clock and a stop may leave the interface stuck
// - sixteen clock pulses or another address reset the interface
// - receiver acks with 0; host ends reads with a 1
// - group commands wait for the stop before executing
// - conversion start in a group begins sampling at the stop
// - output on only with adequate supply and no overvoltage
// - cleared on request keeps the gate low regardless of inputs
// - on request is bit 7 of output control, reset to 1
// - output control is refused until unlocked by device configuration
// - on request 0 then 1 clears all latched faults
// - output enabled state readable in byte and word summary status
// - device configuration holds foldback, glitch filter and warning polarity
// - power cycle turns output off about 4 s, then back on
// - faults latch until cleared; persisting conditions set them again
// - power-up only while the enable input is high
module pths_target
  import pths_pkg::*;
#(
  parameter int unsigned PCYC_CYCLES = PCYC_CYC_DEF,
  parameter logic [7:0]  ID_BYTE0    = 8'h5A,  // arbitrary identity value
  parameter logic [7:0]  ID_BYTE1    = 8'hA5   // arbitrary identity value
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output wire logic       sda_out,
  output wire logic       sda_oe,
  input  wire logic [1:0] addr_strap,
  input  wire logic       low_supply_trip,
  input  wire logic       high_supply_trip,
  input  wire logic       hs_enable,
  output wire logic       gate_on,
  output wire logic       conv_start,
  output wire logic       foldback_en,
  output wire logic [1:0] glitch_sel,
  output wire logic       warn2_pol
);

  // a zero off time would make the power cycle a no-op
  if (PCYC_CYCLES == 0)
  begin : g_bad_pcyc
    $error("PCYC_CYCLES must be at least one");
  end

  typedef struct packed {
    logic           scl_s1, scl_s2, scl_s3;
    logic           sda_s1, sda_s2, sda_s3;
    logic           lsup_s1, lsup_s2;
    logic           hsup_s1, hsup_s2;
    logic           en_s1, en_s2;
    logic [1:0]     strap_s1, strap_s2, strap;
    logic [1:0]     stw;
    logic           strap_ok;
    pths_phase_type ph;
    logic [3:0]     bcnt;
    logic [7:0]     sreg;
    logic           abyte, rw, ack_ok, wseg;
    logic [2:0]     widx;
    logic [7:0]     crc, cmd, d0;
    logic           pend;
    logic [7:0]     pcmd, pd0;
    logic [4:0]     rec;
    logic [7:0]     opctl, dc;
    logic           uv_f, ov_f, cml_f;
    logic [31:0]    pcyc;
    logic           gate_on, conv_start, sda_o, sda_oe;
  } pths_state_type;

  pths_state_type q, d;

  logic       scl_r, scl_f, start_ev, stop_ev;
  logic       addr_hit, lock_hit, pec_bad, exec, exec_pcyc;
  logic       clr_f, do_ack, load_tx;
  logic [1:0] wl, rl;
  logic [7:0] sb, swh, txb;
  logic [23:0] rdv;

  // crc-8 over one byte, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? CRC_POLY : 8'h00);
    end
    return r;
  endfunction : crc8

  // data bytes a write of this command carries
  function automatic logic [1:0] wr_len(input logic [7:0] c);
    unique case (c)
      CMD_CLR_FAULTS, CMD_PWR_CYCLE:                return 2'h0;
      CMD_OPERATION, CMD_DEV_CONFIG, CMD_PMON_CTRL: return 2'h1;
      default:                                      return WLEN_NONE;
    endcase
  endfunction : wr_len

  // read-only command codes, which may be read back
  function automatic logic rd_ok(input logic [7:0] c);
    return c == CMD_STAT_BYTE || c == CMD_STAT_WORD || c == CMD_MFR_ID;
  endfunction : rd_ok

  always_comb
  begin
    d         = q;
    addr_hit  = 1'b0;
    lock_hit  = 1'b0;
    pec_bad   = 1'b0;
    exec      = 1'b0;
    exec_pcyc = 1'b0;
    clr_f     = 1'b0;
    do_ack    = 1'b0;
    load_tx   = 1'b0;
    wl        = WLEN_NONE;
    rl        = 2'h0;
    rdv       = 24'h000000;
    txb       = 8'hFF;

    // two flops on every pin, a third on the bus lines; only stage two and later are read
    d.scl_s1   = scl_in;
    d.scl_s2   = q.scl_s1;
    d.scl_s3   = q.scl_s2;
    d.sda_s1   = sda_in;
    d.sda_s2   = q.sda_s1;
    d.sda_s3   = q.sda_s2;
    d.lsup_s1  = low_supply_trip;
    d.lsup_s2  = q.lsup_s1;
    d.hsup_s1  = high_supply_trip;
    d.hsup_s2  = q.hsup_s1;
    d.en_s1    = hs_enable;
    d.en_s2    = q.en_s1;
    d.strap_s1 = addr_strap;
    d.strap_s2 = q.strap_s1;
    d.conv_start = 1'b0;
    d.sda_o    = 1'b0;

    // bus events from the sampled link clock
    scl_r    = q.scl_s2 & ~q.scl_s3;
    scl_f    = ~q.scl_s2 & q.scl_s3;
    start_ev = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    stop_ev  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;

    // strap caught once, a few cycles after reset release
    if (!q.strap_ok)
    begin
      d.stw = q.stw + 2'h1;
      if (q.stw == 2'h3)
      begin
        d.strap    = q.strap_s2;
        d.strap_ok = 1'b1;
      end
    end

    // summary status shows whether the output is enabled
    sb          = 8'h00;
    sb[SB_OFF]  = ~q.gate_on;
    sb[SB_OV]   = q.ov_f;
    sb[SB_UV]   = q.uv_f;
    sb[SB_CML]  = q.cml_f;
    swh         = 8'h00;
    swh[SW_INPUT] = q.uv_f | q.ov_f;

    // readable data of the current command
    unique case (q.cmd)
      CMD_STAT_BYTE:
      begin
        rl  = 2'h1;
        rdv = {16'h0000, sb};
      end
      CMD_STAT_WORD:
      begin
        rl  = 2'h2;
        rdv = {8'h00, swh, sb};
      end
      CMD_OPERATION:
      begin
        rl  = 2'h1;
        rdv = {16'h0000, q.opctl};
      end
      CMD_DEV_CONFIG:
      begin
        rl  = 2'h1;
        rdv = {16'h0000, q.dc};
      end
      CMD_MFR_ID:
      begin
        rl  = 2'h3;  // block read: count first
        rdv = {ID_BYTE1, ID_BYTE0, MFR_ID_LEN};
      end
      default:
      begin
        rl  = 2'h0;
        rdv = 24'h000000;
      end
    endcase
    // data bytes, then the error code, then released bus
    if (q.widx < {1'b0, rl})
      txb = rdv[8 * q.widx +: 8];
    else if (q.widx == {1'b0, rl})
      txb = q.crc;

    // end of our write segment: length and error code decide
    if ((start_ev || stop_ev) && q.wseg)
    begin
      d.wseg = 1'b0;
      wl     = wr_len(q.cmd);
      if (wl != WLEN_NONE)
      begin
        if (q.widx == {1'b0, wl} + 3'h1)
        begin
          d.pend = 1'b1;  // without code
          d.pcmd = q.cmd;
          d.pd0  = q.d0;
        end
        else if (q.widx == {1'b0, wl} + 3'h2)
        begin
          if (q.crc == 8'h00)
          begin
            d.pend = 1'b1;  // with a good code
            d.pcmd = q.cmd;
            d.pd0  = q.d0;
          end
          else
            pec_bad = 1'b1;  // discarded
        end
      end
    end

    // held commands run only at the stop, in step with the group
    if (stop_ev && d.pend)
    begin
      exec   = 1'b1;
      d.pend = 1'b0;
      unique case (d.pcmd)
        CMD_OPERATION:
        begin
          clr_f   = ~q.opctl[ON_BIT] & d.pd0[ON_BIT];
          d.opctl = d.pd0;
        end
        CMD_CLR_FAULTS: clr_f = 1'b1;
        CMD_DEV_CONFIG: d.dc = d.pd0;
        CMD_PMON_CTRL:  d.conv_start = d.pd0[PMON_CONV];
        CMD_PWR_CYCLE:  exec_pcyc = 1'b1;
        default:        clr_f = 1'b0;
      endcase
    end

    // latched faults; a live condition wins over a clear
    d.uv_f  = ~q.lsup_s2 | (q.uv_f & ~clr_f);
    d.ov_f  = q.hsup_s2 | (q.ov_f & ~clr_f);
    d.cml_f = pec_bad | (q.cml_f & ~clr_f);

    // power cycle off time
    if (exec_pcyc)
      d.pcyc = PCYC_CYCLES;
    else if (q.pcyc != 32'h00000000)
      d.pcyc = q.pcyc - 32'h00000001;

    // gate needs request, supply window, enable and no power cycle
    d.gate_on = q.opctl[ON_BIT] & q.lsup_s2 & ~q.hsup_s2 & q.en_s2
              & (q.pcyc == 32'h00000000);

    // released-data clock pulses count toward bus recovery
    if (start_ev || stop_ev)
      d.rec = 5'h00;
    else if (scl_r)
      d.rec = q.sda_s2 ? q.rec + 5'h01 : 5'h00;

    // byte engine
    if (start_ev)
    begin
      d.ph     = PH_RX;
      d.bcnt   = 4'h0;
      d.abyte  = 1'b1;
      d.sda_oe = 1'b0;
      // only a repeated start after our own write keeps the running code;
      // a receive byte must not inherit the code of the previous frame
      if (!q.wseg)
        d.crc = 8'h00;
    end
    else if (stop_ev)
    begin
      d.ph     = PH_IDLE;
      d.sda_oe = 1'b0;
    end
    else if (q.rec == RECOVER_PULSES)
    begin
      d.ph     = PH_IDLE;
      d.sda_oe = 1'b0;
      d.rec    = 5'h00;
    end
    else
    begin
      unique case (q.ph)
        PH_IDLE, PH_IGN: d.sda_oe = 1'b0;
        PH_RX:
        begin
          if (scl_r)
          begin
            d.sreg = {q.sreg[6:0], q.sda_s2};
            d.bcnt = q.bcnt + 4'h1;
          end
          else if (scl_f && q.bcnt == 4'h8)
          begin
            if (q.abyte)
            begin
              if (q.sreg[7:1] == {ADDR_HI, q.strap})
              begin
                addr_hit = 1'b1;
                do_ack   = 1'b1;
                d.abyte  = 1'b0;
                d.rw     = q.sreg[0];
                d.widx   = 3'h0;
                d.wseg   = ~q.sreg[0];
                // a read continues the code of its write part
                d.crc    = crc8(q.sreg[0] ? q.crc : 8'h00, q.sreg);
              end
              else
                d.ph = PH_IGN;  // other address
            end
            else if (q.widx == 3'h0 && wr_len(q.sreg) == WLEN_NONE
                     && !rd_ok(q.sreg) && q.sreg != CMD_DEV_CONFIG)
              d.ph = PH_IGN;  // unsupported command
            else if (q.widx == 3'h0 && q.sreg == CMD_OPERATION && !q.dc[DC_OPEN])
            begin
              lock_hit = 1'b1;
              d.ph     = PH_IGN;
            end
            else if (q.widx == WIDX_MAX)
              d.ph = PH_IGN;  // too long for any command
            else
            begin
              do_ack = 1'b1;
              if (q.widx == 3'h0)
                d.cmd = q.sreg;
              if (q.widx == 3'h1)
                d.d0 = q.sreg;
              d.crc  = crc8(q.crc, q.sreg);
              d.widx = q.widx + 3'h1;
            end
          end
        end
        PH_ACK:
        begin
          if (scl_f)
          begin
            if (q.rw)
              load_tx = 1'b1;
            else
            begin
              d.ph     = PH_RX;
              d.bcnt   = 4'h0;
              d.sda_oe = 1'b0;
            end
          end
        end
        PH_TX:
        begin
          if (scl_f)
          begin
            if (q.bcnt == 4'h8)
            begin
              d.sda_oe = 1'b0;
              d.ph     = PH_TXACK;
            end
            else
            begin
              d.sda_oe = ~q.sreg[6];
              d.sreg   = {q.sreg[6:0], 1'b0};
              d.bcnt   = q.bcnt + 4'h1;
            end
          end
        end
        PH_TXACK:
        begin
          if (scl_r)
            d.ack_ok = ~q.sda_s2;
          else if (scl_f)
          begin
            if (q.ack_ok)
              load_tx = 1'b1;
            else
              d.ph = PH_IGN;  // host ends the read with a 1
          end
        end
        default: d.ph = PH_IDLE;
      endcase
    end

    // acknowledge a received byte with a low
    if (do_ack)
    begin
      d.ph     = PH_ACK;
      d.sda_oe = 1'b1;
    end
    // first bit of the next byte goes out on the falling edge
    if (load_tx)
    begin
      d.ph     = PH_TX;
      d.sreg   = txb;
      d.sda_oe = ~txb[7];
      d.bcnt   = 4'h1;
      if (q.widx < {1'b0, rl})
        d.crc = crc8(q.crc, txb);
      if (q.widx != 3'h7)
        d.widx = q.widx + 3'h1;
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      q       <= '0;
      q.opctl <= OPCTL_RST;  // on request set at reset
      q.dc    <= DC_RST;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
    end
    else
      q <= d;
  end

  assign sda_out     = q.sda_o;
  assign sda_oe      = q.sda_oe;
  assign gate_on     = q.gate_on;
  assign conv_start  = q.conv_start;
  assign foldback_en = q.dc[DC_FOLD];
  assign glitch_sel  = q.dc[DC_GLT_LSB +: 2];
  assign warn2_pol   = q.dc[DC_WPOL];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_ack_drive;
    q.ph == PH_ACK && q.sda_oe;
  endsequence
  sequence s_refused;
    q.ph == PH_IGN && !q.sda_oe;
  endsequence

  property p_addr_ack;
    addr_hit |=> s_ack_drive;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

  property p_lock;
    lock_hit |=> s_refused ##1 !q.sda_oe;
  endproperty
  a_lock: assert property (p_lock) else $error("locked command was acked");

  property p_pec;
    pec_bad |=> q.cml_f && !exec;
  endproperty
  a_pec: assert property (p_pec) else $error("bad error code not flagged");

  property p_supply;
    (!q.lsup_s2 || q.hsup_s2) |=> !q.gate_on;
  endproperty
  a_supply: assert property (p_supply) else $error("gate on outside supply window");

  property p_off;
    !q.opctl[ON_BIT] |=> !q.gate_on;
  endproperty
  a_off: assert property (p_off) else $error("gate on with request cleared");

  property p_en;
    !q.en_s2 |=> !q.gate_on;
  endproperty
  a_en: assert property (p_en) else $error("gate on with enable low");

  property p_pcyc;
    exec_pcyc |=> (q.pcyc == PCYC_CYCLES) ##1 !q.gate_on [*8];
  endproperty
  a_pcyc: assert property (p_pcyc) else $error("power cycle did not hold gate off");

  property p_defer;
    q.pend && !stop_ev |=> q.pend;
  endproperty
  a_defer: assert property (p_defer) else $error("held command ran before stop");

  property p_fault;
    !q.lsup_s2 |=> q.uv_f;
  endproperty
  a_fault: assert property (p_fault) else $error("live fault not latched");

  property p_recover;
    q.rec == RECOVER_PULSES && !start_ev && !stop_ev |=> q.ph == PH_IDLE && !q.sda_oe;
  endproperty
  a_recover: assert property (p_recover) else $error("recovery pulses ignored");

endmodule : pths_target

// *** inc/pths_pkg.sv ***
package pths_pkg;
  // fixed upper address bits, the strap fills the two low ones
  localparam logic [4:0] ADDR_HI        = 5'h08;
  // command codes
  localparam logic [7:0] CMD_OPERATION  = 8'h01;
  localparam logic [7:0] CMD_CLR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STAT_BYTE  = 8'h78;
  localparam logic [7:0] CMD_STAT_WORD  = 8'h79;
  localparam logic [7:0] CMD_MFR_ID     = 8'h99;
  localparam logic [7:0] CMD_PMON_CTRL  = 8'hD3;
  localparam logic [7:0] CMD_DEV_CONFIG = 8'hD4;
  localparam logic [7:0] CMD_PWR_CYCLE  = 8'hD9;
  // write lengths; NONE marks a command that cannot be written
  localparam logic [1:0] WLEN_NONE      = 2'h3;
  localparam logic [2:0] WIDX_MAX       = 3'h4;
  // output_on_control layout
  localparam int         ON_BIT         = 7;
  localparam logic [7:0] OPCTL_RST      = 8'h80;
  // device configuration layout
  localparam int         DC_FOLD        = 0;
  localparam int         DC_GLT_LSB     = 1;
  localparam int         DC_WPOL        = 3;
  localparam int         DC_OPEN        = 4;
  localparam logic [7:0] DC_RST         = 8'h01;
  localparam int         PMON_CONV      = 0;
  // summary status layout
  localparam int         SB_OFF         = 6;
  localparam int         SB_OV          = 5;
  localparam int         SB_UV          = 3;
  localparam int         SB_CML         = 1;
  localparam int         SW_INPUT       = 5;
  localparam logic [7:0] MFR_ID_LEN     = 8'h02;
  // crc-8 of the packet error code
  localparam logic [7:0] CRC_POLY       = 8'h07;
  // bus recovery pulse count
  localparam logic [4:0] RECOVER_PULSES = 5'h10;
  // power cycle off time
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned PCYC_TIME_MS  = 4000;
  localparam int unsigned PCYC_CYC_DEF  = PCYC_TIME_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_TXACK, PH_IGN
  } pths_phase_type;
endpackage : pths_pkg

// *** bench/pths_host.sv ***
`timescale 1ns/1ps
// bus host: owns the clock line, pulls the data line low when sda_low is set
module pths_host
  import pths_pkg::*;
(
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_wire
);
  localparam real Q = 31.25;  // quarter of the 125 ns bus clock period

  // idle bus: clock high, data released to the pull-up
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // crc-8 over a byte list, init 0
  function automatic logic [7:0] crc8(input logic [7:0] d[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (d[i])
    begin
      c = c ^ d[i];
      for (int b = 0; b < 8; b++)
        c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  // data moves only while the clock is low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda_wire;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_io

  // start, or repeated start between group members
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start

  // data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2 * Q);
  endtask : stop

  // eight bits then the acknowledge; as reader, last=1 ends the read
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(last, ack);
  endtask : byte_io

  // clock pulses with data released, used to unstick the target
  task automatic pulses(input int n);
    logic k;
    scl = 1'b0;
    #Q;
    repeat (n)
      bit_io(1'b1, k);
  endtask : pulses

  // write; pec 0 none, 1 good, 2 corrupted; fin=0 leaves the group open
  task automatic wr(input logic [6:0] a, input logic [7:0] d[$], input logic [1:0] pec,
                    input logic fin, output logic [7:0] ak);
    logic [7:0] q;
    d.push_front({a, 1'b0});
    if (pec != 2'h0)
      d.push_back(crc8(d) ^ {7'h00, pec[1]});
    ak = 8'h00;
    start();
    foreach (d[i])
      byte_io(d[i], 1'b1, q, ak[i]);
    if (fin)
      stop();
  endtask : wr

  // read n bytes plus the error code; without c it is a receive byte
  task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] cmd,
                    input int n, output logic [7:0] r[$]);
    logic [7:0] q;
    logic       k;
    r = {};
    start();
    if (c)
    begin
      byte_io({a, 1'b0}, 1'b1, q, k);
      byte_io(cmd, 1'b1, q, k);
      start();
    end
    byte_io({a, 1'b1}, 1'b1, q, k);
    for (int i = 0; i <= n; i++)
    begin
      byte_io(8'hFF, i == n, q, k);
      r.push_back(q);
    end
    stop();
  endtask : rd
endmodule : pths_host

// *** bench/pths_target_test.sv ***
`timescale 1ns/1ps
module pths_target_test
  import pths_pkg::*;
;
  localparam int         PCYC  = 50;     // short off time keeps the run brief
  localparam logic [7:0] ID0   = 8'h3C;  // arbitrary identity value
  localparam logic [7:0] ID1   = 8'hC3;  // arbitrary identity value
  localparam logic [7:0] SMASK = 8'h6A;  // status bits with a known meaning
  logic       core_clk, rst_b, low_supply_trip, high_supply_trip, hs_enable;
  logic       scl, sda_low, sda_out, sda_oe, gate_on, conv_start;
  logic       foldback_en, warn2_pol;
  logic [1:0] addr_strap, glitch_sel;
  wire logic  sda_w;
  wire logic [6:0] dev;
  int         err_total = 0, total_checks = 0;
  int         conv_n = 0, off_n = 0, off_last = 0;

  // open-drain data wire with pull-up
  assign sda_w = !sda_oe & !sda_low;
  assign dev = {ADDR_HI, addr_strap};

  pths_target #(.PCYC_CYCLES(PCYC), .ID_BYTE0(ID0), .ID_BYTE1(ID1)) u_pths_target (
    .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
    .low_supply_trip(low_supply_trip), .high_supply_trip(high_supply_trip),
    .hs_enable(hs_enable), .gate_on(gate_on), .conv_start(conv_start),
    .foldback_en(foldback_en), .glitch_sel(glitch_sel), .warn2_pol(warn2_pol)
  );

  pths_host u_pths_host (.scl(scl), .sda_low(sda_low), .sda_wire(sda_w));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // convert pulses last one cycle, so they are counted every cycle
  always @(posedge core_clk)
  begin
    if (conv_start === 1'b1)
      conv_n <= conv_n + 1;
    off_n <= (gate_on === 1'b1) ? 0 : off_n + 1;
    if (gate_on === 1'b1 && off_n != 0)
      off_last <= off_n;
  end

  task automatic chk_data(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_data

  task automatic chk_pin(input logic g, input logic e);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_pin

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic set_in(input logic l, input logic h, input logic e);
    cyc(1);
    low_supply_trip = l;
    high_supply_trip = h;
    hs_enable = e;
  endtask : set_in

  function automatic logic [7:0] sb(input logic off, ov, uv, pe);
    return {1'b0, off, ov, 1'b0, uv, 1'b0, pe, 1'b0};
  endfunction : sb

  // reset with a strap code; clears flags picked up while inputs synchronised
  task automatic do_reset(input logic [1:0] s);
    logic [7:0] ak;
    cyc(1);
    rst_b = 1'b0;
    addr_strap = s;
    cyc(16);
    rst_b = 1'b1;
    cyc(12);
    u_pths_host.wr({ADDR_HI, ~s}, '{CMD_CLR_FAULTS}, 2'h0, 1'b1, ak);
    chk_data(ak, 8'h03);
    u_pths_host.wr({ADDR_HI, s}, '{CMD_CLR_FAULTS}, 2'h0, 1'b1, ak);
    chk_data(ak, 8'h00);
  endtask : do_reset

  // read and compare masked data, then the error code over the whole frame
  task automatic rd_chk(input logic c, input logic [7:0] cmd, input logic [7:0] e[$],
                        input logic [7:0] m[$]);
    logic [7:0] r[$];
    logic [7:0] h[$];
    h = {};
    if (c)
      h = '{{dev, 1'b0}, cmd};
    h.push_back({dev, 1'b1});
    u_pths_host.rd(dev, c, cmd, e.size(), r);
    foreach (e[i])
    begin
      chk_data(r[i] & m[i], e[i] & m[i]);
      h.push_back(r[i]);
    end
    chk_data(r[e.size()], u_pths_host.crc8(h));
  endtask : rd_chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // over twice the expected run; a hang ends as a failure
  initial
  begin
    #380000;
    err_total++;
    end_sim();
  end

  initial
  begin : main
    logic [7:0] ak, dc, nv;
    logic       ov, uv;
    logic [2:0] p;
    rst_b = 1'b0;
    addr_strap = 2'h0;
    low_supply_trip = 1'b1;
    high_supply_trip = 1'b0;
    hs_enable = 1'b1;
    void'($urandom(68));
    for (int s = 0; s < 4; s++)
      do_reset(2'(s));
    do_reset(2'($urandom));
    u_pths_host.wr({5'h09, addr_strap}, '{CMD_CLR_FAULTS}, 2'h0, 1'b1, ak);
    chk_data(ak, 8'h03);
    chk_pin(gate_on, 1'b1);
    chk_pin(sda_out, 1'b0);
    chk_data({warn2_pol, glitch_sel, foldback_en}, DC_RST);
    done("reset");
    // locked output control and an unknown code are both refused
    u_pths_host.wr(dev, '{CMD_OPERATION, 8'h00}, 2'h0, 1'b1, ak);
    chk_data(ak, 8'h06);
    u_pths_host.wr(dev, '{8'h55, 8'h00}, 2'h0, 1'b1, ak);
    chk_data(ak, 8'h06);
    cyc(8);
    chk_pin(gate_on, 1'b1);
    done("lock");
    // config with good, corrupted and absent error code; unlock kept set
    dc = DC_RST;
    for (int k = 1; k < 4; k++)
    begin
      nv = {4'h1, 4'($urandom)};
      u_pths_host.wr(dev, '{CMD_DEV_CONFIG, nv}, 2'(k % 3), 1'b1, ak);
      chk_data(ak & {8{k != 2}}, 8'h00);
      if (k != 2)
        dc = nv;
      cyc(8);
      chk_data({warn2_pol, glitch_sel, foldback_en}, dc[3:0]);
    end
    rd_chk(1'b1, CMD_DEV_CONFIG, '{dc}, '{8'hFF});
    rd_chk(1'b1, CMD_STAT_BYTE, '{sb(0, 0, 0, 1)}, '{SMASK});
    done("config");
    // off, then on; the 0-to-1 write also drops the error flag
    u_pths_host.wr(dev, '{CMD_OPERATION, 8'h00}, 2'h1, 1'b1, ak);
    cyc(8);
    chk_pin(gate_on, 1'b0);
    rd_chk(1'b1, CMD_OPERATION, '{8'h00}, '{8'hFF});
    rd_chk(1'b1, CMD_STAT_BYTE, '{sb(1, 0, 0, 1)}, '{SMASK});
    u_pths_host.wr(dev, '{CMD_OPERATION, 8'h80}, 2'h0, 1'b1, ak);
    cyc(8);
    chk_pin(gate_on, 1'b1);
    rd_chk(1'b1, CMD_STAT_WORD, '{sb(0, 0, 0, 0), 8'h00}, '{SMASK, 8'h20});
    done("operation");
    // random supply, overvoltage and enable levels
    ov = 1'b0;
    uv = 1'b0;
    repeat (12)
    begin
      p = 3'($urandom);
      set_in(p[0], p[1], p[2]);
      ov |= p[1];
      uv |= !p[0];
      cyc(8);
      chk_pin(gate_on, p[0] & !p[1] & p[2]);
    end
    set_in(1'b1, 1'b0, 1'b1);
    cyc(8);
    rd_chk(1'b1, CMD_STAT_WORD, '{sb(0, ov, uv, 0), {2'h0, ov | uv, 5'h00}},
           '{SMASK, 8'h20});
    // a clear while overvoltage persists sets the flag again
    set_in(1'b1, 1'b1, 1'b1);
    u_pths_host.wr(dev, '{CMD_CLR_FAULTS}, 2'h1, 1'b1, ak);
    rd_chk(1'b1, CMD_STAT_BYTE, '{sb(1, 1, 0, 0)}, '{SMASK});
    set_in(1'b1, 1'b0, 1'b1);
    u_pths_host.wr(dev, '{CMD_OPERATION, 8'h00}, 2'h0, 1'b1, ak);
    u_pths_host.wr(dev, '{CMD_OPERATION, 8'h80}, 2'h0, 1'b1, ak);
    rd_chk(1'b1, CMD_STAT_BYTE, '{sb(0, 0, 0, 0)}, '{SMASK});
    rd_chk(1'b0, 8'h00, '{sb(0, 0, 0, 0)}, '{SMASK});
    done("faults");
    // group of writes only: neighbour first, ours waits for the one stop
    u_pths_host.wr({ADDR_HI, ~addr_strap}, '{CMD_OPERATION, 8'h00}, 2'h0, 1'b0, ak);
    u_pths_host.wr(dev, '{CMD_OPERATION, 8'h00}, 2'h1, 1'b0, ak);
    chk_data(ak, 8'h00);
    cyc(8);
    chk_pin(gate_on, 1'b1);
    u_pths_host.stop();
    cyc(8);
    chk_pin(gate_on, 1'b0);
    u_pths_host.wr({ADDR_HI, ~addr_strap}, '{CMD_PMON_CTRL, 8'h01}, 2'h0, 1'b0, ak);
    u_pths_host.wr(dev, '{CMD_PMON_CTRL, 8'h01}, 2'h0, 1'b0, ak);
    cyc(8);
    chk_data(16'(conv_n), 16'h0000);
    u_pths_host.stop();
    cyc(8);
    chk_data(16'(conv_n), 16'h0001);
    u_pths_host.wr(dev, '{CMD_OPERATION, 8'h80}, 2'h0, 1'b1, ak);
    done("group");
    // a one-pulse partial frame, then recovery pulses
    u_pths_host.start();
    u_pths_host.pulses(1);
    u_pths_host.stop();
    u_pths_host.pulses(int'(RECOVER_PULSES));
    rd_chk(1'b1, CMD_STAT_BYTE, '{sb(0, 0, 0, 0)}, '{SMASK});
    rd_chk(1'b1, CMD_MFR_ID, '{MFR_ID_LEN, ID0, ID1}, '{8'hFF, 8'hFF, 8'hFF});
    done("recovery");
    // power cycle: off for the set count, back on with no further traffic
    u_pths_host.wr(dev, '{CMD_PWR_CYCLE}, 2'h1, 1'b1, ak);
    cyc(PCYC + 40);
    chk_pin(gate_on, 1'b1);
    chk_pin(off_last >= PCYC - 1 && off_last <= PCYC + 4, 1'b1);
    done("power_cycle");
    end_sim();
  end
endmodule : pths_target_test
